// ---- hw/dac_input_word_decoder.sv ----
`timescale 1ns/10ps
`include "dac_word_consts.svh"

// Functional notes
// - Data write starts that channel's calibration.
// - Word is 24 bits without error checking.
// - Error checking extends word to 32 bits.
// - Word layout: flag, address, select, channel, payload.
// - Act only when address matches strap pins.
// - Select 000/010/100/110 write per-channel registers.
// - Select 011/101 broadcast gain and offset.
// - Select 111 routes to control registers.
// - Data write takes all sixteen payload bits.
// - Gain, offset, clear reset to fixed defaults.
// - Control sub-select picks slew/main/channel/boost/software.
module dac_input_word_decoder (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic SCLK,
   input wire logic SYNC_N,
   input wire logic SDIN,
   input wire logic STRAP_PIN_HI,
   input wire logic STRAP_PIN_LO,
   output dac_word_pkg::chan_regs_t [3:0] CHANNEL_REGS,
   output dac_word_pkg::global_regs_t GLOBAL_REGS,
   output logic [3:0] CAL_START,
   output logic PEC_ENABLE
);

   dac_word_pkg::link_state_t link;
   dac_word_pkg::link_state_t next_link;
   dac_word_pkg::core_state_t core;
   dac_word_pkg::core_state_t next_core;
   logic frame_new;

   function automatic logic [15:0] payload(input logic [23:0] w);
      payload = w[`WORD_DATA_HI:0];
   endfunction

   function automatic logic [12:0] ctrl_payload(input logic [23:0] w);
      ctrl_payload = w[`WORD_CTRL_DATA_HI:0];
   endfunction

   // Frame marker for the link side. It is set while the frame select is
   // inactive and cleared by the first shift clock, so the bit counter
   // restarts with every frame without needing a clock between frames.
   always_ff @(posedge SCLK or posedge RST or posedge SYNC_N)
   begin
      if (RST || SYNC_N)
      begin
         frame_new <= 1'b1;
      end
      else
      begin
         frame_new <= 1'b0;
      end
   end

   // Link side: shift MSB first and count bits. Neither is cleared at frame
   // end, so the finished word stays still until the core has taken it.
   always_comb
   begin
      next_link = link;
      next_link.shift = {link.shift[30:0], SDIN};
      if (frame_new)
      begin
         next_link.count = 6'h01;
      end
      else if (link.count != `COUNT_MAX)
      begin
         next_link.count = link.count + 6'h01;
      end
   end

   always_ff @(posedge SCLK or posedge RST)
   begin
      if (RST)
      begin
         link <= '0;
      end
      else if (!SYNC_N)
      begin
         link <= next_link;
      end
   end

   logic frame_agreed;
   logic strap_hi_agreed;
   logic strap_lo_agreed;
   logic frame_end;
   logic length_ok;
   logic [23:0] word;
   logic [2:0] sel;
   logic [2:0] ctrl_sel;
   logic [1:0] chan_sel;
   logic addressed;

   always_comb
   begin
      frame_agreed = core.frame_sync[1] == core.frame_sync[2];
      strap_hi_agreed = core.strap_hi_sync[1] == core.strap_hi_sync[2];
      strap_lo_agreed = core.strap_lo_sync[1] == core.strap_lo_sync[2];
      frame_end = frame_agreed && core.frame_sync[2] && !core.frame_idle;
      if (core.glob.soft_reg[`SOFT_PEC_BIT])
      begin
         length_ok = link.count == `LEN_PEC;
         word = link.shift[`WORD_PEC_HI:`WORD_PEC_LO];
      end
      else
      begin
         length_ok = link.count == `LEN_PLAIN;
         word = link.shift[`WORD_PLAIN_HI:0];
      end
      sel = word[`WORD_SEL_HI:`WORD_SEL_LO];
      ctrl_sel = word[`WORD_CTRL_SEL_HI:`WORD_CTRL_SEL_LO];
      chan_sel = word[`WORD_CH_HI:`WORD_CH_LO];
      addressed = word[`WORD_DEV_HI] == core.strap_pin_hi
         && word[`WORD_DEV_LO] == core.strap_pin_lo;
   end

   always_comb
   begin
      next_core = core;
      next_core.cal_start = 4'h0;
      next_core.frame_sync = {core.frame_sync[1:0], SYNC_N};
      next_core.strap_hi_sync = {core.strap_hi_sync[1:0], STRAP_PIN_HI};
      next_core.strap_lo_sync = {core.strap_lo_sync[1:0], STRAP_PIN_LO};
      if (frame_agreed)
      begin
         next_core.frame_idle = core.frame_sync[2];
      end
      if (strap_hi_agreed)
      begin
         next_core.strap_pin_hi = core.strap_hi_sync[2];
      end
      if (strap_lo_agreed)
      begin
         next_core.strap_pin_lo = core.strap_lo_sync[2];
      end
      // A read request carries no write here; a mismatched address or a
      // frame of the wrong length changes nothing.
      if (frame_end && length_ok && addressed && !word[`WORD_RW_BIT])
      begin
         unique case (sel)
            `SEL_DATA:
            begin
               next_core.chan[chan_sel].data = payload(word);
               next_core.cal_start[chan_sel] = 1'b1;
            end
            `SEL_GAIN:
            begin
               next_core.chan[chan_sel].gain = payload(word);
            end
            `SEL_OFFSET:
            begin
               next_core.chan[chan_sel].offset = payload(word);
            end
            `SEL_CLEAR:
            begin
               next_core.chan[chan_sel].clear_code = payload(word);
            end
            `SEL_GAIN_ALL, `SEL_OFFSET_ALL:
            begin
               for (int i = 0; i < 4; i++)
               begin
                  if (sel == `SEL_GAIN_ALL)
                  begin
                     next_core.chan[i].gain = payload(word);
                  end
                  else
                  begin
                     next_core.chan[i].offset = payload(word);
                  end
               end
            end
            `SEL_CONTROL:
            begin
               unique case (ctrl_sel)
                  `CTRL_SLEW:
                  begin
                     next_core.chan[chan_sel].slew = ctrl_payload(word);
                  end
                  `CTRL_MAIN:
                  begin
                     next_core.glob.main_ctrl = ctrl_payload(word);
                  end
                  `CTRL_CHANNEL:
                  begin
                     // Range, boost enable and output drive all land here.
                     next_core.chan[chan_sel].control = ctrl_payload(word);
                  end
                  `CTRL_BOOST:
                  begin
                     next_core.glob.boost_ctrl = ctrl_payload(word);
                  end
                  `CTRL_SOFTWARE:
                  begin
                     next_core.glob.soft_reg = ctrl_payload(word);
                  end
                  default:
                  begin
                     next_core.glob = core.glob;
                  end
               endcase
            end
            default:
            begin
               next_core.chan = core.chan;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         core <= '0;
         core.frame_sync <= 3'h7;
         core.frame_idle <= 1'b1;
         for (int i = 0; i < 4; i++)
         begin
            core.chan[i].data <= `RST_DATA;
            core.chan[i].gain <= `RST_GAIN;
            core.chan[i].offset <= `RST_OFFSET;
            core.chan[i].clear_code <= `RST_CLEAR;
            core.chan[i].slew <= `RST_CTRL;
            core.chan[i].control <= `RST_CTRL;
         end
      end
      else
      begin
         core <= next_core;
      end
   end

   assign CHANNEL_REGS = core.chan;
   assign GLOBAL_REGS = core.glob;
   assign CAL_START = core.cal_start;
   assign PEC_ENABLE = core.glob.soft_reg[`SOFT_PEC_BIT];

endmodule // dac_input_word_decoder

// ---- hw/dac_word_consts.svh ----
`ifndef DAC_WORD_CONSTS_SVH
`define DAC_WORD_CONSTS_SVH

// Field positions inside the 24-bit input word, and its place in the 32-bit shift register.
`define WORD_RW_BIT 23
`define WORD_DEV_HI 22
`define WORD_DEV_LO 21
`define WORD_SEL_HI 20
`define WORD_SEL_LO 18
`define WORD_CH_HI 17
`define WORD_CH_LO 16
`define WORD_DATA_HI 15
`define WORD_CTRL_SEL_HI 15
`define WORD_CTRL_SEL_LO 13
`define WORD_CTRL_DATA_HI 12
`define WORD_PLAIN_HI 23
`define WORD_PEC_HI 31
`define WORD_PEC_LO 8

// Frame lengths and bit counter ceiling in shift clocks.
`define LEN_PLAIN 6'h18
`define LEN_PEC 6'h20
`define COUNT_MAX 6'h3F

// Target select codes.
`define SEL_DATA 3'h0
`define SEL_GAIN 3'h2
`define SEL_GAIN_ALL 3'h3
`define SEL_OFFSET 3'h4
`define SEL_OFFSET_ALL 3'h5
`define SEL_CLEAR 3'h6
`define SEL_CONTROL 3'h7

// Control target select codes.
`define CTRL_SLEW 3'h0
`define CTRL_MAIN 3'h1
`define CTRL_CHANNEL 3'h2
`define CTRL_BOOST 3'h3
`define CTRL_SOFTWARE 3'h4

// Reset values.
`define RST_DATA 16'h0000
`define RST_GAIN 16'hFFFF
`define RST_OFFSET 16'h8000
`define RST_CLEAR 16'h0000
`define RST_CTRL 13'h0000

// Packet error check enable inside the software register.
`define SOFT_PEC_BIT 0

`endif

// ---- hw/dac_word_pkg.sv ----
package dac_word_pkg;

   typedef struct packed {
      logic [15:0] data;
      logic [15:0] gain;
      logic [15:0] offset;
      logic [15:0] clear_code;
      logic [12:0] slew;
      logic [12:0] control;
   } chan_regs_t;

   typedef struct packed {
      logic [12:0] main_ctrl;
      logic [12:0] boost_ctrl;
      logic [12:0] soft_reg;
   } global_regs_t;

   typedef struct packed {
      logic [31:0] shift;
      logic [5:0] count;
   } link_state_t;

   typedef struct packed {
      logic [2:0] frame_sync;
      logic [2:0] strap_hi_sync;
      logic [2:0] strap_lo_sync;
      logic frame_idle;
      logic strap_pin_hi;
      logic strap_pin_lo;
      chan_regs_t [3:0] chan;
      global_regs_t glob;
      logic [3:0] cal_start;
   } core_state_t;

endpackage

// ---- verification/serial_host_model.sv ----
`timescale 1ns/10ps
module serial_host_model (
   output logic sclk,
   output logic sync_n,
   output logic sdin
);
   initial
   begin
      sclk = 1'b0;
      sync_n = 1'b1;
      sdin = 1'b0;
   end
   // The shift clock stands still outside frames; released data shows the inverse bit.
   task automatic send(input logic [31:0] w, input int n);
      int i;
      sync_n = 1'b0;
      for (i = n - 1; i >= 0; i--)
      begin
         sdin = w[i];
         #6 sclk = 1'b1;
         #6 sclk = 1'b0;
      end
      #6 sync_n = 1'b1;
      sdin = ~sdin;
   endtask
endmodule // serial_host_model

// ---- verification/dac_input_word_decoder_monitor.sv ----
`timescale 1ns/10ps
module dac_input_word_decoder_monitor (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic SYNC_N,
   input wire dac_word_pkg::chan_regs_t [3:0] CHANNEL_REGS,
   input wire dac_word_pkg::global_regs_t GLOBAL_REGS,
   input wire logic [3:0] CAL_START,
   input wire logic PEC_ENABLE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_cal_one_cycle: assert property (CAL_START != 4'h0 |=> CAL_START == 4'h0)
      else $error("calibration start longer than one cycle");
   a_cal_one_channel: assert property ($onehot0(CAL_START))
      else $error("calibration start on several channels");
   a_cal_after_frame: assert property (
      CAL_START != 4'h0 |-> $past(SYNC_N, 1) && $past(SYNC_N, 2))
      else $error("calibration start inside a frame");
   a_chan_after_frame: assert property (
      $changed(CHANNEL_REGS) |-> $past(SYNC_N, 1) && $past(SYNC_N, 2))
      else $error("channel registers changed inside a frame");
   a_glob_after_frame: assert property (
      $changed(GLOBAL_REGS) |-> $past(SYNC_N, 1) && $past(SYNC_N, 2))
      else $error("global registers changed inside a frame");
   a_pec_tracks_soft: assert property (PEC_ENABLE == GLOBAL_REGS.soft_reg[0])
      else $error("error check enable differs from software register");
   a_data_keeps_trim: assert property (
      CAL_START[0] |-> $stable(CHANNEL_REGS[0].gain) && $stable(CHANNEL_REGS[0].offset))
      else $error("data write disturbed trim registers");
   a_gain_bcast_equal: assert property (
      $changed(CHANNEL_REGS[0].gain) && $changed(CHANNEL_REGS[3].gain)
      |-> CHANNEL_REGS[0].gain == CHANNEL_REGS[3].gain)
      else $error("broadcast gain differs between channels");
endmodule // dac_input_word_decoder_monitor

// ---- verification/dac_input_word_decoder_tb.sv ----
`timescale 1ns/10ps
module dac_input_word_decoder_tb;
   logic ref_clk;
   logic rst;
   logic sclk;
   logic sync_n;
   logic sdin;
   logic [3:0] seen;
   dac_word_pkg::chan_regs_t [3:0] regs;
   dac_word_pkg::global_regs_t glob;
   logic [3:0] cal;
   logic packet_error_check;
   int fail_count;
   int tests_run;
   int c;
   logic strap_hi;
   logic strap_lo;
   logic [12:0] setup;
   // The analog side owns the channel control bit positions; these stand-ins
   // only need to be distinct, since the decoder stores the field whole.
   localparam logic [12:0] range_a = 13'h0001;
   localparam logic [12:0] range_b = 13'h0002;
   localparam logic [12:0] internal_on = 13'h0010;
   localparam logic [12:0] output_drive_on = 13'h0040;
   localparam logic [12:0] boost_converter_on = 13'h0100;
   localparam logic [12:0] boost_cfg = 13'h0123;
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   serial_host_model i_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
   dac_input_word_decoder i_dut (
      .REF_CLK(ref_clk),
      .RST(rst),
      .SCLK(sclk),
      .SYNC_N(sync_n),
      .SDIN(sdin),
      .STRAP_PIN_HI(strap_hi),
      .STRAP_PIN_LO(strap_lo),
      .CHANNEL_REGS(regs),
      .GLOBAL_REGS(glob),
      .CAL_START(cal),
      .PEC_ENABLE(packet_error_check)
   );
   function automatic logic [31:0] mk(logic [1:0] d, logic [2:0] s, logic [1:0] h, logic [15:0] p);
      return {8'h00, 1'b0, d, s, h, p};
   endfunction
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // The gap after a frame also covers the synchroniser delay, so any pulse is caught.
   task automatic wr(input logic [31:0] w, input int n);
      @(posedge ref_clk);
      #1 i_host.send(w, n);
      seen = 4'h0;
      repeat (8)
      begin
         @(posedge ref_clk);
         #1 seen = seen | cal;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Two 200 us settling waits and about thirty frames take some 410 us; the
   // limit leaves room above that without letting a hang run on.
   initial
   begin
      #600000;
      fail_count++;
      end_of_test();
   end
   initial
   begin
      rst = 1'b1;
      strap_hi = 1'b1;
      strap_lo = 1'b0;
      fail_count = 0;
      tests_run = 0;
      repeat (10) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge ref_clk);
      wr(mk(2'h2, 3'h7, 2'h0, {3'h3, boost_cfg}), 24);
      chk("boost_cfg", {3'h0, boost_cfg}, {3'h0, glob.boost_ctrl});
      // The second pass is a range change on the same channel.
      for (c = 0; c < 2; c++)
      begin
         setup = (c == 0) ? range_a : range_b;
         setup = setup | boost_converter_on | internal_on;
         if (c != 0)
         begin
            wr(mk(2'h2, 3'h0, 2'h2, 16'h8000), 24);
         end
         wr(mk(2'h2, 3'h7, 2'h2, {3'h2, setup}), 24);
         chk("ctl2_off", {3'h0, setup}, {3'h0, regs[2].control});
         wr(mk(2'h2, 3'h0, 2'h2, 16'h4000 + c[15:0]), 24);
         chk("data2_setup", 16'h4000 + c[15:0], regs[2].data);
         chk("cal_setup", 16'h0004, {12'h000, seen});
         repeat (20000) @(posedge ref_clk);
         wr(mk(2'h2, 3'h7, 2'h2, {3'h2, setup | output_drive_on}), 24);
         chk("ctl2_on", {3'h0, setup | output_drive_on}, {3'h0, regs[2].control});
      end
      for (c = 0; c < 4; c++)
      begin
         chk("gain", 16'hFFFF, regs[c].gain);
         chk("offset", 16'h8000, regs[c].offset);
         chk("clear", 16'h0000, regs[c].clear_code);
         wr(mk(2'h2, 3'h0, c[1:0], 16'hA5C0 + c[15:0]), 24);
         chk("data", 16'hA5C0 + c[15:0], regs[c].data);
         chk("cal", {12'h000, 4'h1 << c}, {12'h000, seen});
      end
      wr(mk(2'h2, 3'h2, 2'h2, 16'h1111), 24);
      wr(mk(2'h2, 3'h4, 2'h2, 16'h2222), 24);
      wr(mk(2'h2, 3'h6, 2'h2, 16'h3333), 24);
      chk("gain2", 16'h1111, regs[2].gain);
      chk("offset2", 16'h2222, regs[2].offset);
      chk("clear2", 16'h3333, regs[2].clear_code);
      chk("gain1", 16'hFFFF, regs[1].gain);
      wr(mk(2'h2, 3'h3, 2'h1, 16'h0F0F), 24);
      wr(mk(2'h2, 3'h5, 2'h2, 16'h7070), 24);
      for (c = 0; c < 4; c++)
      begin
         chk("gain_all", 16'h0F0F, regs[c].gain);
         chk("offset_all", 16'h7070, regs[c].offset);
      end
      wr(mk(2'h2, 3'h7, 2'h3, 16'h0123), 24);
      wr(mk(2'h2, 3'h7, 2'h0, 16'h2456), 24);
      wr(mk(2'h2, 3'h7, 2'h1, 16'h4789), 24);
      wr(mk(2'h2, 3'h7, 2'h0, 16'h6ABC), 24);
      wr(mk(2'h2, 3'h7, 2'h0, 16'hA111), 24);
      chk("slew3", 16'h0123, {3'h0, regs[3].slew});
      chk("main", 16'h0456, {3'h0, glob.main_ctrl});
      chk("ctl1", 16'h0789, {3'h0, regs[1].control});
      chk("boost", 16'h0ABC, {3'h0, glob.boost_ctrl});
      chk("ctl0", 16'h0000, {3'h0, regs[0].control});
      wr(mk(2'h1, 3'h0, 2'h1, 16'hDEAD), 24);
      wr(mk(2'h2, 3'h0, 2'h1, 16'hBEEF) | 32'h0080_0000, 24);
      wr(mk(2'h2, 3'h0, 2'h1, 16'hCAFE) >> 1, 23);
      chk("data1", 16'hA5C1, regs[1].data);
      // Move the straps so that the other address is the one that counts.
      strap_hi = 1'b0;
      strap_lo = 1'b1;
      repeat (5) @(posedge ref_clk);
      wr(mk(2'h1, 3'h0, 2'h1, 16'hDEAD), 24);
      chk("data1_strap", 16'hDEAD, regs[1].data);
      wr(mk(2'h2, 3'h0, 2'h1, 16'hBEEF), 24);
      chk("data1_keep", 16'hDEAD, regs[1].data);
      strap_hi = 1'b1;
      strap_lo = 1'b0;
      repeat (5) @(posedge ref_clk);
      wr(mk(2'h2, 3'h7, 2'h0, 16'h8001), 24);
      chk("pec_on", 16'h0001, {15'h0000, packet_error_check});
      wr(mk(2'h2, 3'h0, 2'h0, 16'h1357), 24);
      chk("data0", 16'hA5C0, regs[0].data);
      wr(mk(2'h2, 3'h0, 2'h0, 16'h1357) << 8, 32);
      chk("data0", 16'h1357, regs[0].data);
      wr(mk(2'h2, 3'h7, 2'h0, 16'h8000) << 8, 32);
      chk("pec_off", 16'h0000, {15'h0000, packet_error_check});
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      chk("data0_rst", 16'h0000, regs[0].data);
      chk("gain3_rst", 16'hFFFF, regs[3].gain);
      chk("offset1_rst", 16'h8000, regs[1].offset);
      chk("clear2_rst", 16'h0000, regs[2].clear_code);
      end_of_test();
   end
endmodule // dac_input_word_decoder_tb
bind dac_input_word_decoder dac_input_word_decoder_monitor i_mon (.REF_CLK(REF_CLK), .RST(RST),
   .SYNC_N(SYNC_N), .CHANNEL_REGS(CHANNEL_REGS), .GLOBAL_REGS(GLOBAL_REGS),
   .CAL_START(CAL_START), .PEC_ENABLE(PEC_ENABLE));
